//--- rtl/ccp_params.svh
// Constants for the configuration controller pin block: widths and timing counts.
// Assumes a 10 MHz core clock; every ms and ns time below is converted to cycles at that rate.
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH

// ==========================================================================
// Widths
`define CCP_ADDR_W        21
`define CCP_DQ_W          16
`define CCP_CFG_W         8
`define CCP_PAGE_W        3
`define CCP_IDX_W         18
`define CCP_CNT_W         20
`define CCP_SYNC_STAGES   2

// ==========================================================================
// Clock rate and conversion of times to cycles (least times round up)
`define CCP_CORE_CLK_KHZ  10000
`define CCP_NS_TO_CYC_UP(ns) ((((ns) * `CCP_CORE_CLK_KHZ) + 999999) / 1000000)

// ==========================================================================
// Power-on hold times
`define CCP_POR_SHORT_MS  2
`define CCP_POR_LONG_MS   100
`define CCP_POR_SHORT_CYC (`CCP_POR_SHORT_MS * `CCP_CORE_CLK_KHZ)
`define CCP_POR_LONG_CYC  (`CCP_POR_LONG_MS * `CCP_CORE_CLK_KHZ)

// ==========================================================================
// Flash and target timing
`define CCP_FLASH_ACC_NS  120
`define CCP_WE_LOW_NS     100
`define CCP_DONE_WAIT_NS  60
`define CCP_INIT_PULSE_NS 500
`define CCP_RD_CYC   (`CCP_NS_TO_CYC_UP(`CCP_FLASH_ACC_NS) + `CCP_SYNC_STAGES)
`define CCP_WE_CYC   `CCP_NS_TO_CYC_UP(`CCP_WE_LOW_NS)
`define CCP_DONE_CYC (`CCP_NS_TO_CYC_UP(`CCP_DONE_WAIT_NS) + `CCP_SYNC_STAGES)
`define CCP_INIT_CYC `CCP_NS_TO_CYC_UP(`CCP_INIT_PULSE_NS)
`define CCP_BUSY_SETTLE_CYC (`CCP_SYNC_STAGES + 1)

// ==========================================================================
// Image size in 16-bit words per page
`define CCP_IMAGE_WORDS   1024

`endif

//--- rtl/ccp_pkg.sv
// Types shared by the configuration controller pin block.
// Assumes ccp_params.svh is on the include path.
`include "ccp_params.svh"

package ccp_pkg;

	// ======================================================================
	// Controller states, Gray coded along the load path except the SEND to FETCH return
	typedef enum logic [3:0] {
		ST_POR      = 4'h0,
		ST_WAIT_REL = 4'h1,
		ST_FETCH    = 4'h3,
		ST_READ     = 4'h2,
		ST_SEND     = 4'h6,
		ST_CHECK    = 4'h7,
		ST_DONE     = 4'h5,
		ST_INIT     = 4'h4,
		ST_WRITE    = 4'hC,
		ST_WR_BUSY  = 4'hD,
		ST_EXT      = 4'hF
	} ccp_state_t;

	// ======================================================================
	// One flash word on its way to the target
	typedef struct packed {
		logic                 last;
		logic [`CCP_DQ_W-1:0] data;
	} ccp_word_t;

	// Flash write command from the local side
	typedef struct packed {
		logic [`CCP_ADDR_W-1:0] addr;
		logic [`CCP_DQ_W-1:0]   data;
	} ccp_wr_req_t;

	// Flash bus pins driven by the controller
	typedef struct packed {
		logic [`CCP_ADDR_W-1:0] addr;
		logic [`CCP_DQ_W-1:0]   dq;
		logic                   dq_oe;
		logic                   ce_n;
		logic                   oe_n;
		logic                   we_n;
		logic                   reset_n;
		logic                   ctl_oe;
	} ccp_flash_out_t;

endpackage

//--- rtl/ccp_cfg_link.sv
// Link-side byte sender: turns handed-over flash words into clock and data toward the target.
// Runs on the link clock; the word is held stable by the core while its toggle is pending.
`timescale 1ns/1ns

module ccp_cfg_link import ccp_pkg::*; (
	input  wire logic                 link_clk_i,
	input  wire logic                 core_resetn_i,
	input  wire logic                 req_tgl_i,
	input  wire ccp_word_t            word_i,
	output logic                      ack_tgl_o,
	output logic                      cfg_clock_out_o,
	output logic [`CCP_CFG_W-1:0]     cfg_data_o
);

	logic       rst_s1_q;
	logic       rst_s2_q;
	logic       req_s1_q;
	logic       req_s2_q;
	logic       req_s3_q;
	logic       busy_q;
	logic [2:0] ph_q;
	ccp_word_t  word_q;
	logic       new_req;

	// ======================================================================
	// Crossings into the link domain
	always_ff @(posedge link_clk_i) begin
		rst_s1_q <= core_resetn_i;
		rst_s2_q <= rst_s1_q;
		req_s1_q <= req_tgl_i;
		req_s2_q <= req_s1_q;
		req_s3_q <= req_s2_q;
	end

	assign new_req = req_s2_q ^ req_s3_q;

	// ======================================================================
	// Sequencer and handshake
	always_ff @(posedge link_clk_i) begin
		if (!rst_s2_q) begin
			busy_q    <= 1'h0;
			ph_q      <= 3'h0;
			word_q    <= '0;
			ack_tgl_o <= 1'h0;
		end else if (!busy_q) begin
			if (new_req) begin
				busy_q <= 1'h1;
				ph_q   <= 3'h0;
				word_q <= word_i;
			end
		end else begin
			ph_q <= ph_q + 3'h1;
			if ((ph_q == 3'h3 && !word_q.last) || ph_q == 3'h5) begin
				busy_q    <= 1'h0;
				ack_tgl_o <= ~ack_tgl_o;
			end
		end
	end

	// ======================================================================
	// Clock and data pins
	always_ff @(posedge link_clk_i) begin
		if (!rst_s2_q) begin
			cfg_clock_out_o <= 1'h0;
			cfg_data_o      <= '0;
		end else if (busy_q) begin
			// [R02] Clock always driven
			cfg_clock_out_o <= ~ph_q[0];
			// [R01] Data on rising edge
			case (ph_q)
				3'h0: begin
					cfg_data_o <= word_q.data[7:0];
				end
				3'h2: begin
					cfg_data_o <= word_q.data[15:8];
				end
				3'h4: begin
					// [R20] Data low after
					cfg_data_o <= '0;
				end
				default: begin
					cfg_data_o <= cfg_data_o;
				end
			endcase
		end
	end

endmodule // ccp_cfg_link

//--- rtl/ccp_top.sv
// Configuration controller pin block: power-on hold, image load from flash, target handshake.
// Assumes pins arrive asynchronously, the link clock runs free, and pins combine
// output and enable into the wire levels outside this module.
`timescale 1ns/1ns

// How it works
// [R01] Target data changes only with a rising edge of the generated clock.
// [R02] The configuration clock is only ever driven out, never sampled.
// [R03] Done-sense is sampled after the last data to flag a load error.
// [R04] The target keeps done-sense low while the release line is low.
// [R05] A test-port start command pulses the init-configuration output low.
// [R06] The release line is pulled low until the power-on count finishes.
// [R07] Power-on count holds release for 2 ms or 100 ms, pin selected.
// [R08] An outside party may keep the release line low for longer.
// [R09] Loading starts only once the release line is seen high.
// [R10] The flash latches the full address during every write cycle.
// [R11] The bus master drives flash data in command and write cycles.
// [R12] In read cycles the flash drives data back to the controller.
// [R13] Flash chip select low means active; high means standby.
// [R14] Flash reset low holds it in reset and refuses writes.
// [R15] Flash output enable is asserted only during read cycles.
// [R16] Each write pulses the write strobe; its rising edge latches.
// [R17] The flash write-protect pin is never driven by the controller.
// [R18] Flash ready/busy high marks a finished write or erase.
// [R19] Delay select low gives 100 ms, high gives 2 ms.
// [R20] After loading completes the target data lines are driven low.
// [R21] Three page-select pins, top bit first, choose one of eight images.
// [R22] Only one master drives the flash bus; the idle one floats.
module ccp_top import ccp_pkg::*; #(
	parameter int POR_SHORT_CYC = `CCP_POR_SHORT_CYC,
	parameter int POR_LONG_CYC  = `CCP_POR_LONG_CYC,
	parameter int IMAGE_WORDS   = `CCP_IMAGE_WORDS
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   link_clk_i,
	input  wire logic                   powerup_delay_select_i,
	input  wire logic [`CCP_PAGE_W-1:0] image_page_select_i,
	input  wire logic                   release_line_i,
	output logic                        release_line_o,
	output logic                        release_line_oe_o,
	input  wire logic                   done_sense_in_i,
	input  wire logic                   init_cmd_i,
	output logic                        init_conf_n_o,
	output logic                        cfg_clock_out_o,
	output logic [`CCP_CFG_W-1:0]       cfg_data_o,
	output logic                        cfg_done_o,
	output logic                        cfg_error_o,
	output ccp_flash_out_t              flash_o,
	input  wire logic [`CCP_DQ_W-1:0]   flash_dq_i,
	input  wire logic                   flash_ready_busy_i,
	input  wire logic                   ext_req_i,
	output logic                        ext_grant_o,
	input  wire logic                   wr_req_i,
	input  wire ccp_wr_req_t            wr_cmd_i,
	output logic                        wr_done_o
);

	localparam int CW = `CCP_CNT_W;
	localparam int IW = `CCP_IDX_W;
	localparam logic [CW-1:0] POR_S_LIM  = CW'(POR_SHORT_CYC - 1);
	localparam logic [CW-1:0] POR_L_LIM  = CW'(POR_LONG_CYC - 1);
	localparam logic [CW-1:0] RD_LIM     = CW'(`CCP_RD_CYC - 1);
	localparam logic [CW-1:0] WE_LIM     = CW'(`CCP_WE_CYC - 1);
	localparam logic [CW-1:0] DONE_LIM   = CW'(`CCP_DONE_CYC - 1);
	localparam logic [CW-1:0] INIT_LIM   = CW'(`CCP_INIT_CYC - 1);
	localparam logic [CW-1:0] SETTLE_LIM = CW'(`CCP_BUSY_SETTLE_CYC);
	localparam logic [IW-1:0] LAST_IDX   = IW'(IMAGE_WORDS - 1);

	// ======================================================================
	// Elaboration checks
	if (POR_SHORT_CYC < 1 || POR_LONG_CYC < 1 || POR_LONG_CYC > (1 << CW) ||
			POR_SHORT_CYC > (1 << CW)) begin : g_bad_por
		$error("ccp_top: power-on counts do not fit the counter");
	end
	if (IMAGE_WORDS < 1 || IMAGE_WORDS > (1 << IW)) begin : g_bad_image
		$error("ccp_top: image size does not fit one page");
	end

	// ======================================================================
	// Declarations
	ccp_state_t              state_q;
	logic [CW-1:0]           cnt_q;
	logic [IW-1:0]           idx_q;
	logic [`CCP_PAGE_W-1:0]  page_q;
	logic [7:0]              pin_s1_q;
	logic [7:0]              pin_s2_q;
	logic [`CCP_DQ_W-1:0]    dq_s1_q;
	logic [`CCP_DQ_W-1:0]    dq_s2_q;
	logic                    ack_s1_q;
	logic                    ack_s2_q;
	logic                    req_tgl_q;
	ccp_word_t               word_q;
	logic                    ack_tgl;
	logic [7:0]              pin_raw;
	logic [`CCP_PAGE_W-1:0]  page_s;
	logic                    sel_s;
	logic                    rel_s;
	logic                    done_s;
	logic                    rb_s;
	logic                    ext_s;
	logic [CW-1:0]           por_lim;
	logic                    por_done;
	logic                    go_fetch;
	logic                    rd_done;
	logic                    send_ok;
	logic                    chk_done;
	logic                    take_init;
	logic                    take_wr;
	logic                    take_ext;
	logic                    init_done;
	logic                    we_done;
	logic                    wr_end;
	logic                    ext_done;

	// ======================================================================
	// Pin synchronisers
	assign pin_raw = {ext_req_i, flash_ready_busy_i, done_sense_in_i, release_line_i,
		powerup_delay_select_i, image_page_select_i};

	always_ff @(posedge core_clk_i) begin
		pin_s1_q <= pin_raw;
		pin_s2_q <= pin_s1_q;
		dq_s1_q  <= flash_dq_i;
		dq_s2_q  <= dq_s1_q;
		ack_s1_q <= ack_tgl;
		ack_s2_q <= ack_s1_q;
	end

	assign page_s = pin_s2_q[2:0];
	assign sel_s  = pin_s2_q[3];
	assign rel_s  = pin_s2_q[4];
	assign done_s = pin_s2_q[5];
	assign rb_s   = pin_s2_q[6];
	assign ext_s  = pin_s2_q[7];

	// ======================================================================
	// Events of the sequence
	// [R19] Select low is long
	assign por_lim   = sel_s ? POR_S_LIM : POR_L_LIM;
	assign por_done  = (state_q == ST_POR) && (cnt_q >= por_lim);
	// [R09] Wait for line high; [R08] tolerates outside hold
	assign go_fetch  = (state_q == ST_WAIT_REL) && rel_s && rb_s;
	assign rd_done   = (state_q == ST_READ) && (cnt_q == RD_LIM);
	assign send_ok   = (state_q == ST_SEND) && (ack_s2_q == req_tgl_q);
	assign chk_done  = (state_q == ST_CHECK) && (cnt_q == DONE_LIM);
	assign take_init = (state_q == ST_DONE) && init_cmd_i;
	assign take_wr   = (state_q == ST_DONE) && !init_cmd_i && wr_req_i;
	assign take_ext  = (state_q == ST_DONE) && !init_cmd_i && !wr_req_i && ext_s;
	assign init_done = (state_q == ST_INIT) && (cnt_q == INIT_LIM);
	assign we_done   = (state_q == ST_WRITE) && (cnt_q == WE_LIM);
	// [R18] Ready marks write end
	assign wr_end    = (state_q == ST_WR_BUSY) && (cnt_q >= SETTLE_LIM) && rb_s;
	assign ext_done  = (state_q == ST_EXT) && !ext_s;

	// ======================================================================
	// State, counter and image position
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			state_q <= ST_POR;
			cnt_q   <= '0;
			idx_q   <= '0;
			page_q  <= '0;
		end else begin
			cnt_q <= cnt_q + CW'(1);
			case (state_q)
				// [R07] Power-on count
				ST_POR: begin
					if (por_done) begin
						state_q <= ST_WAIT_REL;
						cnt_q   <= '0;
					end
				end
				ST_WAIT_REL: begin
					if (go_fetch) begin
						state_q <= ST_FETCH;
						// [R21] Page picks image
						page_q  <= page_s;
						idx_q   <= '0;
					end
				end
				ST_FETCH: begin
					state_q <= ST_READ;
					cnt_q   <= '0;
				end
				ST_READ: begin
					if (rd_done) begin
						state_q <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (send_ok && word_q.last) begin
						state_q <= ST_CHECK;
						cnt_q   <= '0;
					end else if (send_ok) begin
						state_q <= ST_FETCH;
						idx_q   <= idx_q + IW'(1);
					end
				end
				ST_CHECK: begin
					if (chk_done) begin
						state_q <= ST_DONE;
					end
				end
				ST_DONE: begin
					cnt_q <= '0;
					if (take_init) begin
						state_q <= ST_INIT;
					end else if (take_wr) begin
						state_q <= ST_WRITE;
					end else if (take_ext) begin
						state_q <= ST_EXT;
					end
				end
				ST_INIT: begin
					if (init_done) begin
						state_q <= ST_WAIT_REL;
					end
				end
				ST_WRITE: begin
					if (we_done) begin
						state_q <= ST_WR_BUSY;
						cnt_q   <= '0;
					end
				end
				ST_WR_BUSY: begin
					if (wr_end) begin
						state_q <= ST_DONE;
					end
				end
				ST_EXT: begin
					if (ext_done) begin
						state_q <= ST_DONE;
					end
				end
				default: begin
					state_q <= ST_POR;
					cnt_q   <= '0;
				end
			endcase
		end
	end

	// ======================================================================
	// Flash bus pins
	// The write-protect pin has no port at all, so it can never fight the board strap.
	// [R17] Write protect undriven
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			flash_o.addr    <= '0;
			flash_o.dq      <= '0;
			flash_o.dq_oe   <= 1'h0;
			flash_o.ce_n    <= 1'h1;
			flash_o.oe_n    <= 1'h1;
			flash_o.we_n    <= 1'h1;
			// [R14] Flash held in reset
			flash_o.reset_n <= 1'h0;
			flash_o.ctl_oe  <= 1'h1;
		end else begin
			if (por_done) begin
				flash_o.reset_n <= 1'h1;
			end
			// [R13] Select on read; [R15] output enable only for reads; [R12] flash drives
			if (state_q == ST_FETCH) begin
				flash_o.addr <= {page_q, idx_q};
				flash_o.ce_n <= 1'h0;
				flash_o.oe_n <= 1'h0;
			end
			if (rd_done) begin
				flash_o.ce_n <= 1'h1;
				flash_o.oe_n <= 1'h1;
			end
			// [R10] Address held; [R11] data driven; [R16] strobe pulsed
			if (take_wr) begin
				flash_o.addr  <= wr_cmd_i.addr;
				flash_o.dq    <= wr_cmd_i.data;
				flash_o.dq_oe <= 1'h1;
				flash_o.ce_n  <= 1'h0;
				flash_o.we_n  <= 1'h0;
			end
			if (we_done) begin
				flash_o.we_n <= 1'h1;
			end
			// Data and select are held one cycle past the strobe's rising edge.
			if (state_q == ST_WR_BUSY && cnt_q == '0) begin
				flash_o.dq_oe <= 1'h0;
				flash_o.ce_n  <= 1'h1;
			end
			// [R22] Float for outside master
			if (take_ext) begin
				flash_o.ctl_oe <= 1'h0;
				flash_o.dq_oe  <= 1'h0;
			end
			if (ext_done) begin
				flash_o.ctl_oe <= 1'h1;
			end
		end
	end

	// ======================================================================
	// Word handover to the link domain
	// The word changes only together with the toggle and then waits for the echo,
	// so the link may capture all of it once its synchronised toggle moves.
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			req_tgl_q <= 1'h0;
			word_q    <= '0;
		end else if (rd_done) begin
			word_q.data <= dq_s2_q;
			word_q.last <= (idx_q == LAST_IDX);
			req_tgl_q   <= ~req_tgl_q;
		end
	end

	// ======================================================================
	// Target handshake and status
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			release_line_o    <= 1'h0;
			release_line_oe_o <= 1'h1;
			init_conf_n_o     <= 1'h1;
			cfg_done_o        <= 1'h0;
			cfg_error_o       <= 1'h0;
			ext_grant_o       <= 1'h0;
			wr_done_o         <= 1'h0;
		end else begin
			release_line_o <= 1'h0;
			wr_done_o      <= wr_end;
			// [R06] Pull low until count ends
			if (por_done) begin
				release_line_oe_o <= 1'h0;
			end
			// [R05] Start pulse to target
			if (take_init) begin
				init_conf_n_o <= 1'h0;
			end
			if (init_done) begin
				init_conf_n_o <= 1'h1;
			end
			if (go_fetch) begin
				cfg_done_o  <= 1'h0;
				cfg_error_o <= 1'h0;
			end
			// [R03] Done sense checked; [R04] low sense counts as error
			if (chk_done) begin
				cfg_done_o  <= 1'h1;
				cfg_error_o <= ~done_s;
			end
			if (take_ext) begin
				ext_grant_o <= 1'h1;
			end
			if (ext_done) begin
				ext_grant_o <= 1'h0;
			end
		end
	end

	// ======================================================================
	// Link-side sender
	ccp_cfg_link u_link (
		.link_clk_i      (link_clk_i),
		.core_resetn_i   (resetn_i),
		.req_tgl_i       (req_tgl_q),
		.word_i          (word_q),
		.ack_tgl_o       (ack_tgl),
		.cfg_clock_out_o (cfg_clock_out_o),
		.cfg_data_o      (cfg_data_o)
	);

endmodule // ccp_top

//--- verification/ccp_top_asserts.sv
// Checker for the configuration controller pin block, bound to ccp_top.
// Assumes the delay select changes only while reset is held.
`timescale 1ns/1ns
`include "ccp_params.svh"

module ccp_top_asserts import ccp_pkg::*; #(
	parameter int POR_SHORT_CYC = 20,
	parameter int POR_LONG_CYC  = 50
) (
	input wire logic                 core_clk_i,
	input wire logic                 resetn_i,
	input wire logic                 link_clk_i,
	input wire logic                 powerup_delay_select_i,
	input wire logic                 release_line_i,
	input wire logic                 release_line_o,
	input wire logic                 release_line_oe_o,
	input wire logic                 init_conf_n_o,
	input wire logic                 cfg_clock_out_o,
	input wire logic [`CCP_CFG_W-1:0] cfg_data_o,
	input wire logic                 cfg_done_o,
	input wire logic                 cfg_error_o,
	input wire ccp_flash_out_t       flash_o,
	input wire logic                 ext_grant_o
);
	// ======================================================================
	// Cycles since reset release, saturating
	logic [20:0] por_q;
	int          lim;
	assign lim = powerup_delay_select_i ? POR_SHORT_CYC : POR_LONG_CYC;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			por_q <= 21'h000000;
		else if (por_q != 21'h1FFFFF)
			por_q <= por_q + 21'h000001;
	end

	// ======================================================================
	// Properties
	chk_por_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(por_q < lim - 1) |-> release_line_oe_o && !flash_o.reset_n) else $error("release too early");
	chk_por_release: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		(por_q >= lim + 2) |-> !release_line_oe_o && flash_o.reset_n) else $error("release too late");
	chk_rel_low: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		release_line_oe_o |-> !release_line_o) else $error("release line driven high");
	chk_load_after_rel: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		$fell(flash_o.oe_n) && flash_o.ctl_oe |-> $past(release_line_i, 2) && $past(release_line_i, 3))
		else $error("read before release seen high");
	chk_rd_excl: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		!flash_o.oe_n && flash_o.ctl_oe |-> !flash_o.ce_n && flash_o.we_n && !flash_o.dq_oe)
		else $error("read cycle malformed");
	chk_rd_len: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		$fell(flash_o.oe_n) |-> !flash_o.oe_n [*4] ##1 flash_o.oe_n) else $error("read length");
	chk_we_pulse: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		$fell(flash_o.we_n) |-> !flash_o.ce_n && flash_o.dq_oe ##1 flash_o.we_n && flash_o.dq_oe
		&& $stable(flash_o.addr) && $stable(flash_o.dq)) else $error("write strobe malformed");
	chk_ext_float: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		ext_grant_o |-> !flash_o.ctl_oe && !flash_o.dq_oe) else $error("bus not floated");
	chk_init_pulse: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		$fell(init_conf_n_o) |-> !init_conf_n_o [*5] ##1 init_conf_n_o) else $error("init pulse");
	chk_done_data: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		$rose(cfg_done_o) |-> cfg_data_o == 8'h00 && !cfg_clock_out_o) else $error("data not low");
	chk_err_valid: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		cfg_error_o |-> cfg_done_o) else $error("error without done");
	chk_data_edge: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
		!$stable(cfg_data_o) |-> $rose(cfg_clock_out_o)) else $error("data moved off clock rise");
endmodule // ccp_top_asserts

bind ccp_top ccp_top_asserts #(.POR_SHORT_CYC(POR_SHORT_CYC), .POR_LONG_CYC(POR_LONG_CYC)) u_chk (
	.core_clk_i, .resetn_i, .link_clk_i, .powerup_delay_select_i, .release_line_i,
	.release_line_o, .release_line_oe_o, .init_conf_n_o, .cfg_clock_out_o, .cfg_data_o,
	.cfg_done_o, .cfg_error_o, .flash_o, .ext_grant_o);

//--- verification/ccp_far_model.sv
// Far side of the block: flash die, target done signal and the pulled-up release wire.
// Assumes the bench drives the outside hold and the done and busy-speed knobs.
`timescale 1ns/1ns
`include "ccp_params.svh"

module ccp_far_model import ccp_pkg::*; (
	input  wire ccp_flash_out_t         flash_i,
	input  wire logic                   rel_oe_i,
	input  wire logic                   ext_hold_i,
	input  wire logic                   done_ok_i,
	input  wire logic                   slow_i,
	output logic [`CCP_DQ_W-1:0]        dq_o,
	output logic                        rdy_o,
	output logic                        rel_o,
	output logic                        done_o,
	output logic [`CCP_ADDR_W-1:0]      wr_addr_o,
	output logic [`CCP_DQ_W-1:0]        wr_data_o
);
	// ======================================================================
	// Target and release wire
	logic [`CCP_DQ_W-1:0] pat;
	// Pull-up wire; any party may hold it low.
	assign rel_o = !(rel_oe_i || ext_hold_i);
	// Done-sense kept low while the release wire is low.
	assign done_o = rel_o && done_ok_i;

	// ======================================================================
	// Flash die; the write-protect input is tied on the board and not modelled.
	assign pat = {flash_i.addr[20:18], flash_i.addr[12:0]} ^ 16'hC35A;
	// Drives only while selected and read-enabled, else the inverse.
	assign dq_o = (flash_i.ctl_oe && !flash_i.ce_n && !flash_i.oe_n) ? pat : ~pat;
	initial rdy_o = 1'b1;
	// Latch on strobe rise, refused in reset, busy then ready.
	always @(posedge flash_i.we_n) begin
		if (flash_i.ctl_oe && !flash_i.ce_n && flash_i.dq_oe && flash_i.reset_n) begin
			wr_addr_o = flash_i.addr;
			wr_data_o = flash_i.dq;
			rdy_o = 1'b0;
			#(slow_i ? 2000 : 300);
			rdy_o = 1'b1;
		end
	end
endmodule // ccp_far_model

//--- verification/ccp_top_tb_top.sv
// Self-checking bench for ccp_top with small power-on counts and four-word images.
// Assumes the far-side model and the bound checker are compiled beside it.
`timescale 1ns/1ns

module ccp_top_tb_top import ccp_pkg::*;;
	logic           clk = 1'b0;
	logic           lclk = 1'b0;
	logic           rstn = 1'b0;
	logic           sel = 1'b0;
	logic [2:0]     page = 3'h0;
	logic           init_cmd = 1'b0;
	logic           wr_req = 1'b0;
	ccp_wr_req_t    wr_cmd = '0;
	logic           ext_req = 1'b0;
	logic           ext_hold = 1'b0;
	logic           done_ok = 1'b1;
	logic           slow = 1'b0;
	logic           rel_oe, rel_w, done_s, init_n, cclk, cdone, cerr, grant, rdy, wr_done;
	logic [7:0]     cdata;
	ccp_flash_out_t fl;
	logic [15:0]    fdq, m_data;
	logic [20:0]    m_addr;
	logic [7:0]     cap[$];
	int             failures = 0;
	int             check_count = 0;

	always #50 clk = ~clk;
	initial begin
		#7;
		forever #24 lclk = ~lclk;
	end
	// Data is stable at the falling edge, so sampling there avoids a race.
	always @(negedge cclk) cap.push_back(cdata);

	ccp_top #(.POR_SHORT_CYC(20), .POR_LONG_CYC(50), .IMAGE_WORDS(4)) uut (
		.core_clk_i(clk), .resetn_i(rstn), .link_clk_i(lclk), .powerup_delay_select_i(sel),
		.image_page_select_i(page), .release_line_i(rel_w), .release_line_o(),
		.release_line_oe_o(rel_oe), .done_sense_in_i(done_s), .init_cmd_i(init_cmd),
		.init_conf_n_o(init_n), .cfg_clock_out_o(cclk), .cfg_data_o(cdata), .cfg_done_o(cdone),
		.cfg_error_o(cerr), .flash_o(fl), .flash_dq_i(fdq), .flash_ready_busy_i(rdy),
		.ext_req_i(ext_req), .ext_grant_o(grant), .wr_req_i(wr_req), .wr_cmd_i(wr_cmd),
		.wr_done_o(wr_done));
	ccp_far_model far (.flash_i(fl), .rel_oe_i(rel_oe), .ext_hold_i(ext_hold),
		.done_ok_i(done_ok), .slow_i(slow), .dq_o(fdq), .rdy_o(rdy), .rel_o(rel_w),
		.done_o(done_s), .wr_addr_o(m_addr), .wr_data_o(m_data));

	// ======================================================================
	// Helpers
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task automatic do_reset(input logic s, input logic [2:0] p);
		rstn = 1'b0;
		sel = s;
		page = p;
		cyc(5);
		cap.delete();
		rstn = 1'b1;
	endtask
	task automatic wait_done(input logic v);
		for (int i = 0; i < 3000 && cdone !== v; i++) cyc(1);
		cyc(2);
		chk("done level", v, cdone);
	endtask
	task automatic chk_image(input logic [2:0] p);
		logic [15:0] w;
		chk("byte count", 9, cap.size());
		for (int i = 0; i < 4; i++) begin
			w = {p, 13'(i)} ^ 16'hC35A;
			chk("low byte", w[7:0], cap[2*i]);
			chk("high byte", w[15:8], cap[2*i+1]);
		end
		chk("tail byte", 8'h00, cap[8]);
	endtask

	// ======================================================================
	// Scenarios
	task automatic t_por_long();
		ext_hold = 1'b1;
		do_reset(1'b0, 3'h3);
		cyc(40);
		chk("release hold", 1, rel_oe);
		cyc(20);
		chk("release drive", 0, rel_oe);
		chk("flash reset", 1, fl.reset_n);
		cyc(20);
		chk("read held off", 1, fl.oe_n);
		ext_hold = 1'b0;
		wait_done(1'b1);
		chk("load error", 0, cerr);
		chk("clock idle", 0, cclk);
		chk("data low", 0, cdata);
		chk_image(3'h3);
	endtask
	task automatic t_por_short_err();
		done_ok = 1'b0;
		do_reset(1'b1, 3'h5);
		cyc(15);
		chk("release hold", 1, rel_oe);
		cyc(10);
		chk("release drive", 0, rel_oe);
		wait_done(1'b1);
		chk("load error", 1, cerr);
		chk_image(3'h5);
		done_ok = 1'b1;
	endtask
	task automatic t_init();
		int n = 0;
		cap.delete();
		init_cmd = 1'b1;
		cyc(1);
		init_cmd = 1'b0;
		repeat (10) begin
			n += (init_n === 1'b0);
			cyc(1);
		end
		chk("init pulse", 5, n);
		wait_done(1'b1);
		chk("load error", 0, cerr);
		chk_image(3'h5);
	endtask
	task automatic t_write(input logic s, input logic [20:0] a, input logic [15:0] d);
		int n;
		slow = s;
		wr_cmd = {a, d};
		wr_req = 1'b1;
		cyc(1);
		wr_req = 1'b0;
		for (n = 0; n < 200 && wr_done !== 1'b1; n++) cyc(1);
		chk("write done", 1, wr_done);
		chk("write waits busy", 1, n >= (s ? 20 : 3));
		chk("write address", a, m_addr);
		chk("write data", d, m_data);
	endtask
	task automatic t_ext();
		int n;
		ext_req = 1'b1;
		for (n = 0; n < 10 && grant !== 1'b1; n++) cyc(1);
		chk("grant", 1, grant);
		chk("pins float", 0, fl.ctl_oe);
		ext_req = 1'b0;
		cyc(6);
		chk("grant drop", 0, grant);
		chk("pins back", 1, fl.ctl_oe);
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		t_por_long();
		t_por_short_err();
		t_init();
		t_write(1'b0, 21'h1F0A5C, 16'hA55A);
		t_write(1'b1, 21'h0003C3, 16'h0FF0);
		t_ext();
		print_verdict();
	end
	// The whole sequence needs well under a thousand cycles; this allows thirty thousand.
	initial begin
		#3000000;
		failures++;
		print_verdict();
	end
endmodule // ccp_top_tb_top
